// File: include/stt_defs.vh
`ifndef STT_DEFS_VH
`define STT_DEFS_VH

// Register word offsets (byte addresses, word aligned)
`define STT_OFF_CTRL    4'h0
`define STT_OFF_RELOAD  4'h4
`define STT_OFF_CURRENT 4'h8
`define STT_OFF_CALIB   4'hc
`define STT_OFF_IRQ_ST  4'h0
`define STT_OFF_IRQ_MSK 4'h4

// Address map: bit 4 selects the interrupt page
`define STT_ADDR_W      5

// Control and status fields
`define STT_CTRL_ENABLE 0
`define STT_CTRL_TICKEN 1
`define STT_CTRL_CLKSRC 2
`define STT_CTRL_ZFLAG  16

// Interrupt status fields
`define STT_IRQ_WRAP    0
`define STT_IRQ_W       1

`define STT_CNT_W       24
`define STT_CNT_ZERO    24'h000000
`define STT_CNT_ONE     24'h000001
`define STT_RST_CTRL    3'h0
`define STT_RST_RELOAD  24'h000000
`define STT_RST_CNT     24'h000000

`endif

// File: core/stt_timer.v
// Notes on behaviour
// - Count lives in bits 23:0; a read returns the count of its wait-state cycle, one cycle before it completes.
// - Any write to the current-count register clears the count to zero.
// - That clearing write also clears the reached-zero flag.
// - No calibration register or calibration function exists.
// - Enabled counter decrements to zero, reloads next edge, then keeps counting.
// - Reaching zero sets flag bit 16; reading control register clears it.
// - A clearing write raises no tick request on its own.
// - While the core is halted in debug, the count holds.
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`include "stt_defs.vh"

module stt_timer (
   input  wire        i_ref_clk,
   input  wire        i_nrst,
   input  wire        i_clk_en,
   input  wire        i_dbg_halt,
   input  wire [4:0]  i_avs_address,
   input  wire        i_avs_read,
   input  wire        i_avs_write,
   input  wire [31:0] i_avs_writedata,
   output wire        o_avs_waitrequest,
   output reg  [31:0] o_avs_readdata,
   output wire [23:0] o_count,
   output wire        o_reached_zero_flag,
   output reg         o_tick_pend,
   output wire        o_irq
);

   // Bus handshake: one wait state per request
   localparam [0:0] BUS_IDLE   = 1'b0;
   localparam [0:0] BUS_ANSWER = 1'b1;

   reg  [0:0]  bus_state;
   reg  [0:0]  next_bus_state;
   reg  [23:0] count;
   reg  [23:0] next_count;
   reg  [23:0] reload;
   reg  [23:0] next_reload;
   reg  [2:0]  ctrl;
   reg  [2:0]  next_ctrl;
   reg         irq_mask;
   reg         next_irq_mask;
   reg  [31:0] next_readdata;
   reg         next_tick_pend;
   reg         sel_ctrl;
   reg         sel_reload;
   reg         sel_current;
   reg         sel_istat;
   reg         sel_imask;

   wire        zflag;
   wire        irq_status;
   wire        ack;
   wire        req;
   wire        page_irq;
   wire [3:0]  off;
   wire        do_wr;
   wire        do_rd;
   wire        sample_rd;
   wire        wr_ctrl;
   wire        wr_reload;
   wire        wr_current;
   wire        wr_imask;
   wire        rd_ctrl;
   wire        rd_istat;
   wire        running;
   wire        at_one;
   wire        at_zero;
   wire        hit_zero;
   wire        clr_zflag;

   // Interrupt page is selected by address bit 4
   assign ack       = (bus_state == BUS_ANSWER);
   assign req       = (i_avs_read | i_avs_write) & ~ack;
   assign page_irq  = i_avs_address[4];
   assign off       = i_avs_address[3:0];
   assign do_wr     = i_clk_en & i_avs_write & ack;
   assign do_rd     = i_clk_en & i_avs_read & ack;
   assign sample_rd = i_clk_en & i_avs_read & req;

   // Register select decode
   always @* begin
      sel_ctrl    = 1'b0;
      sel_reload  = 1'b0;
      sel_current = 1'b0;
      sel_istat   = 1'b0;
      sel_imask   = 1'b0;
      if (page_irq) begin
         case (off)
            `STT_OFF_IRQ_ST:  sel_istat = 1'b1;
            `STT_OFF_IRQ_MSK: sel_imask = 1'b1;
            default:          sel_istat = 1'b0;
         endcase
      end else begin
         case (off)
            `STT_OFF_CTRL:    sel_ctrl = 1'b1;
            `STT_OFF_RELOAD:  sel_reload = 1'b1;
            `STT_OFF_CURRENT: sel_current = 1'b1;
            default:          sel_ctrl = 1'b0;
         endcase
      end
   end

   assign wr_ctrl    = do_wr & sel_ctrl;
   assign wr_reload  = do_wr & sel_reload;
   assign wr_current = do_wr & sel_current;
   assign wr_imask   = do_wr & sel_imask;
   assign rd_ctrl    = do_rd & sel_ctrl;
   assign rd_istat   = do_rd & sel_istat;

   assign running    = ctrl[`STT_CTRL_ENABLE] & ~i_dbg_halt;
   assign at_one     = (count == `STT_CNT_ONE);
   assign at_zero    = (count == `STT_CNT_ZERO);
   assign hit_zero   = i_clk_en & running & ~wr_current & at_one;
   assign clr_zflag  = rd_ctrl | wr_current;

   // Output view of internal state
   assign o_avs_waitrequest   = req;
   assign o_count             = count;
   assign o_reached_zero_flag = zflag;
   assign o_irq               = irq_status & irq_mask;

   // Waitrequest high in the first cycle of each request
   always @* begin
      next_bus_state = bus_state;
      case (bus_state)
         BUS_IDLE: begin
            if (i_avs_read | i_avs_write) begin
               next_bus_state = BUS_ANSWER;
            end
         end
         BUS_ANSWER: begin
            next_bus_state = BUS_IDLE;
         end
         default: begin
            next_bus_state = BUS_IDLE;
         end
      endcase
   end

   // Clock enable low freezes every flop
   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         bus_state <= BUS_IDLE;
      end else if (i_clk_en) begin
         bus_state <= next_bus_state;
      end
   end

   // Down counter: load on zero, clear on write
   always @* begin
      next_count = count;
      if (wr_current) begin
         next_count = `STT_CNT_ZERO;
      end else if (running) begin
         if (at_zero) begin
            next_count = reload;
         end else begin
            next_count = count - `STT_CNT_ONE;
         end
      end
   end

   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         count <= `STT_RST_CNT;
      end else if (i_clk_en) begin
         count <= next_count;
      end
   end

   always @* begin
      next_reload = reload;
      if (wr_reload) begin
         next_reload = i_avs_writedata[23:0];
      end
   end

   always @* begin
      next_ctrl = ctrl;
      if (wr_ctrl) begin
         next_ctrl = i_avs_writedata[2:0];
      end
   end

   always @* begin
      next_irq_mask = irq_mask;
      if (wr_imask) begin
         next_irq_mask = i_avs_writedata[`STT_IRQ_WRAP];
      end
   end

   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         reload <= `STT_RST_RELOAD;
      end else if (i_clk_en) begin
         reload <= next_reload;
      end
   end

   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl <= `STT_RST_CTRL;
      end else if (i_clk_en) begin
         ctrl <= next_ctrl;
      end
   end

   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_mask <= 1'b0;
      end else if (i_clk_en) begin
         irq_mask <= next_irq_mask;
      end
   end

   always @* begin
      next_readdata = 32'h00000000;
      if (page_irq) begin
         case (off)
            `STT_OFF_IRQ_ST:  next_readdata[`STT_IRQ_WRAP] = irq_status;
            `STT_OFF_IRQ_MSK: next_readdata[`STT_IRQ_WRAP] = irq_mask;
            default:          next_readdata = 32'h00000000;
         endcase
      end else begin
         case (off)
            `STT_OFF_CTRL: begin
               next_readdata[2:0]             = ctrl;
               next_readdata[`STT_CTRL_ZFLAG] = zflag | hit_zero;
            end
            `STT_OFF_RELOAD:  next_readdata[23:0] = reload;
            `STT_OFF_CURRENT: next_readdata[23:0] = count;
            default:          next_readdata = 32'h00000000;
         endcase
      end
   end

   // Read data captured while the request waits
   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_avs_readdata <= 32'h00000000;
      end else if (sample_rd) begin
         o_avs_readdata <= next_readdata;
      end
   end

   always @* begin
      next_tick_pend = hit_zero & ctrl[`STT_CTRL_TICKEN];
   end

   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_tick_pend <= 1'b0;
      end else if (i_clk_en) begin
         o_tick_pend <= next_tick_pend;
      end
   end

   // Sticky flags: a set in the same cycle beats a clear
   stt_sticky #(
      .RST_VAL (1'b0)
   ) u_zflag (
      .i_ref_clk (i_ref_clk),
      .i_nrst    (i_nrst),
      .i_set     (hit_zero),
      .i_clr     (clr_zflag),
      .o_flag    (zflag)
   );

   stt_sticky #(
      .RST_VAL (1'b0)
   ) u_irq_status (
      .i_ref_clk (i_ref_clk),
      .i_nrst    (i_nrst),
      .i_set     (hit_zero),
      .i_clr     (rd_istat),
      .o_flag    (irq_status)
   );

endmodule

module stt_sticky #(
   parameter [0:0] RST_VAL = 1'b0
) (
   input  wire i_ref_clk,
   input  wire i_nrst,
   input  wire i_set,
   input  wire i_clr,
   output reg  o_flag
);

   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_flag <= RST_VAL;
      end else if (i_set) begin
         o_flag <= 1'b1;
      end else if (i_clr) begin
         o_flag <= 1'b0;
      end
   end

endmodule

// File: dv/stt_timer_properties.sv
module stt_timer_properties (
   input wire        i_ref_clk,
   input wire        i_nrst,
   input wire        i_clk_en,
   input wire        i_dbg_halt,
   input wire [4:0]  i_avs_address,
   input wire        i_avs_read,
   input wire        i_avs_write,
   input wire        o_avs_waitrequest,
   input wire [31:0] o_avs_readdata,
   input wire [23:0] o_count,
   input wire        o_reached_zero_flag,
   input wire        o_tick_pend
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   wire go    = i_clk_en && !o_avs_waitrequest;
   wire wclr  = go && i_avs_write && i_avs_address == 5'h08;
   wire rdone = go && i_avs_read;
   sequence s_hit;
      !wclr && i_clk_en && !i_dbg_halt && o_count == 24'h1 ##1 o_count == 24'h0;
   endsequence
   property p_clr; wclr |=> o_count == 24'h0 && !o_reached_zero_flag; endproperty
   property p_quiet; wclr |=> !o_tick_pend; endproperty
   property p_halt; i_dbg_halt && !wclr |=> $stable(o_count); endproperty
   property p_step;
      !wclr ##1 o_count != $past(o_count) |-> $past(o_count) == 24'h0 ||
         o_count == $past(o_count) - 24'h1;
   endproperty
   property p_rd; rdone && i_avs_address == 5'h08 |-> o_avs_readdata == {8'h00, $past(o_count)};
   endproperty
   property p_cal; rdone && i_avs_address == 5'h0c |-> o_avs_readdata == 32'h0; endproperty
   property p_flag; s_hit |-> o_reached_zero_flag; endproperty
   property p_pend; o_tick_pend |-> o_count == 24'h0 && o_reached_zero_flag; endproperty
   a_clr: assert property (p_clr) else $error("clear write failed");
   a_quiet: assert property (p_quiet) else $error("tick on clear write");
   a_halt: assert property (p_halt) else $error("count moved in halt");
   a_step: assert property (p_step) else $error("bad count step");
   a_rd: assert property (p_rd) else $error("bad count read");
   a_cal: assert property (p_cal) else $error("calibration not zero");
   a_flag: assert property (p_flag) else $error("flag not set");
   a_pend: assert property (p_pend) else $error("pend without zero");
endmodule

// File: dv/stt_timer_test.sv
bind stt_timer stt_timer_properties u_chk (.*);
module stt_timer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_ref_clk = 1'b0, i_nrst = 1'b0, i_clk_en = 1'b1, i_dbg_halt = 1'b0;
   logic        i_avs_read = 1'b0, i_avs_write = 1'b0;
   logic [4:0]  i_avs_address = 5'h00;
   logic [31:0] i_avs_writedata = 32'h0;
   wire         o_avs_waitrequest, o_reached_zero_flag, o_tick_pend, o_irq;
   wire  [31:0] o_avs_readdata;
   wire  [23:0] o_count;
   int          fail_count = 0, n_compared = 0;
   stt_timer u_dut (.*);
   always #5 i_ref_clk = ~i_ref_clk;
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge i_ref_clk);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_write <= w;
      i_avs_read <= !w;
      @(posedge i_ref_clk);
      while (o_avs_waitrequest !== 1'b0) @(posedge i_ref_clk);
      q = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      @(negedge i_ref_clk);
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      acc(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      logic [31:0] q;
      acc(1'b0, a, 32'h0, q);
      chk("readdata", q, e);
   endtask
   task automatic wirq(input logic p);
      repeat (300) if (o_irq !== 1'b1) @(negedge i_ref_clk);
      chk("irq", {31'h0, o_irq}, 32'h1);
      chk("tick_pend", {31'h0, o_tick_pend}, {31'h0, p});
   endtask
   task automatic close_out;
      if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge i_ref_clk);
      i_nrst <= 1'b1;
      rd(5'h08, 32'h0);
      rd(5'h00, 32'h0);
      rd(5'h0c, 32'h0);
      rd(5'h18, 32'h0);
      wr(5'h04, 32'h00000040);
      wr(5'h14, 32'h00000001);
      wr(5'h00, 32'h00000003);
      @(posedge i_ref_clk);
      i_dbg_halt <= 1'b1;
      repeat (20) @(posedge i_ref_clk);
      chk("count", {8'h00, o_count}, 32'h00000040);
      i_dbg_halt <= 1'b0;
      i_clk_en <= 1'b0;
      repeat (10) @(posedge i_ref_clk);
      chk("count", {8'h00, o_count}, 32'h00000040);
      i_clk_en <= 1'b1;
      wirq(1'b1);
      wr(5'h00, 32'h00000000);
      chk("flag", {31'h0, o_reached_zero_flag}, 32'h1);
      wr(5'h08, 32'h00ffffff);
      chk("flag", {31'h0, o_reached_zero_flag}, 32'h0);
      rd(5'h08, 32'h0);
      rd(5'h10, 32'h1);
      rd(5'h10, 32'h0);
      chk("irq", {31'h0, o_irq}, 32'h0);
      wr(5'h00, 32'h00000001);
      wirq(1'b0);
      rd(5'h00, 32'h00010001);
      rd(5'h00, 32'h00000001);
      close_out();
   end
   initial begin
      repeat (3000) @(posedge i_ref_clk);
      fail_count++;
      close_out();
   end
endmodule
